// ### src/spmsp_consts.svh
// Register indices, field positions, reset values and sizes of the port
`ifndef SPMSP_CONSTS_SVH
`define SPMSP_CONSTS_SVH

// Register indices; byte address is four times the index
`define SPMSP_IDX_CTRL 16'h2540
`define SPMSP_IDX_FLAG 16'h2541
`define SPMSP_IDX_DATA 16'h2542
`define SPMSP_IDX_EXT 16'h2543
`define SPMSP_IDX_VPM 16'h277F

`define SPMSP_CTRL_RST 8'h10
`define SPMSP_EXT_RST 8'h02
`define SPMSP_VPM_RST 3'h0

// Flag register bit positions
`define SPMSP_F_DONE 7
`define SPMSP_F_WRITE_COLLISION_FLAG 6
`define SPMSP_F_TXFULL 3
`define SPMSP_F_TXEMPTY 2
`define SPMSP_F_RXFULL 1
`define SPMSP_F_RXEMPTY 0

`define SPMSP_VPM_BIG 3'h3
`define SPMSP_DEPTH_BIG 256
`define SPMSP_DEPTH_SMALL 16
`define SPMSP_HALF_LAST 4'hF
`define SPMSP_BIT_LAST 3'h7

`endif

// ### src/spmsp_pkg.sv
// Types shared by the serial port files
package spmsp_pkg;
   typedef struct packed {
      logic irq_en;
      logic port_en;
      logic rsvd;
      logic ctl_sel;
      logic idle_lvl;
      logic phase;
      logic [1:0] rate_lo;
   } spmsp_ctrl_t;

   typedef struct packed {
      logic [1:0] cnt_sel;
      logic [3:0] rsvd;
      logic [1:0] rate_hi;
   } spmsp_ext_t;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic ss_n;
   } spmsp_pins_t;

   typedef enum logic [1:0] {
      SPMSP_IDLE = 2'b00,
      SPMSP_MXFER = 2'b01,
      SPMSP_SXFER = 2'b10,
      SPMSP_SSKIP = 2'b11
   } spmsp_state_t;
endpackage : spmsp_pkg

// ### src/spmsp_fifo.sv
// Byte FIFO whose usable depth switches between small and large
`include "spmsp_consts.svh"
module spmsp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = `SPMSP_DEPTH_BIG,
   parameter int SMALL = `SPMSP_DEPTH_SMALL,
   parameter int AW = 8
) (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, low
   input wire logic big_i, // Use full depth
   input wire logic push_i, // Write strobe
   input wire logic [W-1:0] wdata_i, // Write data
   input wire logic pop_i, // Read strobe
   output logic [W-1:0] rdata_o, // Head entry
   output logic full_o, // No room
   output logic empty_o // Nothing held
);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d, last;
   logic [AW:0] cnt_q, cnt_d, lim;
   logic do_push, do_pop;

   // Resize only while empty: pointers are not remapped
   assign lim = big_i ? (AW+1)'(DEPTH) : (AW+1)'(SMALL);
   assign last = AW'(lim - (AW+1)'(1));
   assign full_o = cnt_q == lim;
   assign empty_o = cnt_q == '0;
   assign rdata_o = mem[rd_q];
   assign do_push = push_i & ~full_o;
   assign do_pop = pop_i & ~empty_o;

   always_comb begin
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (do_push) wr_d = (wr_q >= last) ? '0 : wr_q + AW'(1);
      if (do_pop) rd_d = (rd_q >= last) ? '0 : rd_q + AW'(1);
      if (do_push & ~do_pop) cnt_d = cnt_q + (AW+1)'(1);
      if (do_pop & ~do_push) cnt_d = cnt_q - (AW+1)'(1);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge hclk) begin
      if (do_push) mem[wr_q] <= wdata_i;
   end
endmodule : spmsp_fifo

// ### src/spmsp_rate_div.sv
// Divider giving a one-cycle tick every half serial clock period
module spmsp_rate_div #(
   parameter int CW = 9
) (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, low
   input wire logic run_i, // Count while high
   input wire logic [CW-1:0] half_i, // Half period minus one
   output logic tick_o // Half period pulse
);
   logic [CW-1:0] cnt_q, cnt_d;
   logic tick_d;

   always_comb begin
      cnt_d = cnt_q + CW'(1);
      tick_d = 1'b0;
      if (!run_i) begin
         cnt_d = '0;
      end else if (cnt_q >= half_i) begin
         cnt_d = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= '0;
         tick_o <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_o <= tick_d;
      end
   end
endmodule : spmsp_rate_div

// ### src/spmsp_port.sv
// Serial port, master or slave, with AHB-Lite register access
// Operation
// - Master write of data buffer starts an 8-bit full-duplex exchange.
// - After completion a data buffer read returns the received byte.
// - Slave shifts a preloaded byte out on the external clock.
// - Slave with nothing loaded makes no exchange for that transfer.
// - Slave received byte is readable once its own transfer completes.
// - Control bit 7 enables the completion interrupt, reset zero.
// - Control bit 6 enables the port, disabled after reset.
// - Control bit 4 selects master, resets to one.
// - Idle serial clock follows the idle-clock-level bit.
// - Equal level and phase: sample rising, change falling; else reverse.
// - Rate code divides system clock by 8 to 1024.
// - Extended rate bits 1:0 reset 2, control rate bits reset 0.
// - Status bit 7 sets on completion; software clears it.
// - Status bit 6 sets on data write with transmit FIFO full.
// - Status bits 3 and 2 show transmit FIFO full and empty.
// - Status bits 1 and 0 show receive FIFO full and empty.
// - Extended bits 7:6 choose how many bytes set the flag.
// - FIFOs hold 256 entries when voice path mux is 3, else 16.
`include "spmsp_consts.svh"
module spmsp_port
   import spmsp_pkg::*;
(
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Always OKAY
   output logic xfer_irq, // Completion interrupt
   input wire logic spi_sck_i, // Clock pin in
   output logic spi_sck_o, // Clock pin out
   output logic spi_sck_oe, // Clock pin drive
   input wire logic spi_mosi_i, // Master-out pin in
   output logic spi_mosi_o, // Master-out pin out
   output logic spi_mosi_oe, // Master-out drive
   input wire logic spi_miso_i, // Master-in pin in
   output logic spi_miso_o, // Master-in pin out
   output logic spi_miso_oe, // Master-in drive
   input wire logic spi_ss_n_i // Slave select, low
);
   spmsp_ctrl_t ctrl_q, ctrl_d;
   spmsp_ext_t ext_q, ext_d;
   logic [2:0] vpm_q, vpm_d;
   logic done_q, done_d, write_collision_flag_q, write_collision_flag_d;
   logic irq_q, irq_d;
   spmsp_state_t state_q, state_d;
   logic [3:0] half_q, half_d;
   logic [2:0] bits_q, bits_d;
   logic [1:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, rx_q, rx_d, rx_nx;
   logic sck_q, sck_d, moe_q, moe_d, soe_q, soe_d;
   spmsp_pins_t s1_q, s2_q, s3_q;
   logic mi1_q, mi2_q;
   logic pend_q, pend_d, wr_q, wr_d, rdy_q, rdy_d;
   logic [15:0] idx_q, idx_d;
   logic [31:0] rd_q, rd_d;
   logic tick;
   logic tx_push, tx_pop, rx_push, rx_pop;
   logic [7:0] tx_rdata, rx_rdata;
   logic tx_full, tx_empty, rx_full, rx_empty;
   logic big, en, mst;
   logic rise, fall, samp, shft, din;
   logic xfer_end, done_set, done_clr, write_collision_flag_set, write_collision_flag_clr;

   // Half period minus one, in system clocks
   function automatic logic [8:0] rate_half(input logic [3:0] code);
      case (code)
         4'h3: rate_half = 9'h00F;
         4'h4: rate_half = 9'h01F;
         4'h5: rate_half = 9'h007;
         4'h6: rate_half = 9'h03F;
         4'h7: rate_half = 9'h07F;
         4'h8: rate_half = 9'h0FF;
         4'h9: rate_half = 9'h1FF;
         // Code 2 and the reserved codes divide by 8
         default: rate_half = 9'h003;
      endcase
   endfunction : rate_half

   // True when this edge captures input data
   function automatic logic is_sample(input logic r, input logic f,
                                      input spmsp_ctrl_t c);
      is_sample = (c.idle_lvl == c.phase) ? r : f;
   endfunction : is_sample

   assign big = vpm_q == `SPMSP_VPM_BIG;
   assign en = ctrl_q.port_en;
   assign mst = ctrl_q.ctl_sel;

   spmsp_fifo u_tx (
      .hclk(hclk),
      .hresetn(hresetn),
      .big_i(big),
      .push_i(tx_push),
      .wdata_i(hwdata[7:0]),
      .pop_i(tx_pop),
      .rdata_o(tx_rdata),
      .full_o(tx_full),
      .empty_o(tx_empty)
   );

   spmsp_fifo u_rx (
      .hclk(hclk),
      .hresetn(hresetn),
      .big_i(big),
      .push_i(rx_push),
      .wdata_i(rx_nx),
      .pop_i(rx_pop),
      .rdata_o(rx_rdata),
      .full_o(rx_full),
      .empty_o(rx_empty)
   );

   spmsp_rate_div u_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .run_i(state_q == SPMSP_MXFER),
      .half_i(rate_half({ext_q.rate_hi, ctrl_q.rate_lo})),
      .tick_o(tick)
   );

   // Edges of the clock in use: own clock as master, pin as slave
   always_comb begin
      if (state_q == SPMSP_MXFER) begin
         rise = tick & ~sck_q;
         fall = tick & sck_q;
         din = mi2_q;
      end else begin
         rise = s2_q.sck & ~s3_q.sck;
         fall = ~s2_q.sck & s3_q.sck;
         din = s2_q.mosi;
      end
      samp = is_sample(rise, fall, ctrl_q);
      shft = (rise | fall) & ~samp;
      rx_nx = samp ? {rx_q[6:0], din} : rx_q;
   end

   // Register access
   always_comb begin
      pend_d = 1'b0;
      rdy_d = 1'b1;
      wr_d = wr_q;
      idx_d = idx_q;
      rd_d = rd_q;
      ctrl_d = ctrl_q;
      ext_d = ext_q;
      vpm_d = vpm_q;
      tx_push = 1'b0;
      rx_pop = 1'b0;
      done_clr = 1'b0;
      write_collision_flag_clr = 1'b0;
      write_collision_flag_set = 1'b0;
      if (pend_q) begin
         if (wr_q) begin
            case (idx_q)
               `SPMSP_IDX_CTRL: begin
                  ctrl_d = spmsp_ctrl_t'(hwdata[7:0]);
                  ctrl_d.rsvd = 1'b0;
               end
               `SPMSP_IDX_FLAG: begin
                  done_clr = ~hwdata[`SPMSP_F_DONE];
                  write_collision_flag_clr = ~hwdata[`SPMSP_F_WRITE_COLLISION_FLAG];
               end
               `SPMSP_IDX_DATA: begin
                  write_collision_flag_set = tx_full;
                  tx_push = ~tx_full;
               end
               `SPMSP_IDX_EXT: begin
                  ext_d = spmsp_ext_t'(hwdata[7:0]);
                  ext_d.rsvd = 4'h0;
               end
               `SPMSP_IDX_VPM: vpm_d = hwdata[2:0];
               default: ;
            endcase
         end else begin
            case (idx_q)
               `SPMSP_IDX_CTRL: rd_d = {24'h0, ctrl_q};
               `SPMSP_IDX_FLAG: begin
                  rd_d = 32'h0;
                  rd_d[`SPMSP_F_DONE] = done_q;
                  rd_d[`SPMSP_F_WRITE_COLLISION_FLAG] = write_collision_flag_q;
                  rd_d[`SPMSP_F_TXFULL] = tx_full;
                  rd_d[`SPMSP_F_TXEMPTY] = tx_empty;
                  rd_d[`SPMSP_F_RXFULL] = rx_full;
                  rd_d[`SPMSP_F_RXEMPTY] = rx_empty;
               end
               `SPMSP_IDX_DATA: begin
                  // Reads pop the receive side only, so no clash
                  rd_d = rx_empty ? 32'h0 : {24'h0, rx_rdata};
                  rx_pop = 1'b1;
               end
               `SPMSP_IDX_EXT: rd_d = {24'h0, ext_q};
               `SPMSP_IDX_VPM: rd_d = {29'h0, vpm_q};
               default: rd_d = 32'h0;
            endcase
         end
      end else if (hsel & hready & htrans[1]) begin
         // One wait state so read data leaves a flop
         pend_d = 1'b1;
         rdy_d = 1'b0;
         wr_d = hwrite;
         idx_d = haddr[17:2];
      end
   end

   // Transfer engine
   always_comb begin
      state_d = state_q;
      half_d = half_q;
      bits_d = bits_q;
      sh_d = sh_q;
      rx_d = rx_nx;
      sck_d = sck_q;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      xfer_end = 1'b0;
      unique case (state_q)
         SPMSP_IDLE: begin
            sck_d = ctrl_q.idle_lvl;
            half_d = 4'h0;
            bits_d = 3'h0;
            rx_d = 8'h00;
            if (en & mst & ~tx_empty) begin
               tx_pop = 1'b1;
               sh_d = tx_rdata;
               state_d = SPMSP_MXFER;
            end else if (en & ~mst & s3_q.ss_n & ~s2_q.ss_n) begin
               if (!tx_empty) begin
                  tx_pop = 1'b1;
                  sh_d = tx_rdata;
                  state_d = SPMSP_SXFER;
               end else begin
                  state_d = SPMSP_SSKIP;
               end
            end
         end
         SPMSP_MXFER: begin
            if (!en | !mst) begin
               state_d = SPMSP_IDLE;
            end else if (tick) begin
               sck_d = ~sck_q;
               half_d = half_q + 4'h1;
               // Leading shift edge of phase 1 presents bit 7 unshifted
               if (shft & (half_q != 4'h0)) sh_d = {sh_q[6:0], 1'b0};
               if (half_q == `SPMSP_HALF_LAST) begin
                  xfer_end = 1'b1;
                  rx_push = 1'b1;
                  state_d = SPMSP_IDLE;
               end
            end
         end
         SPMSP_SXFER: begin
            if (!en | mst | s2_q.ss_n) begin
               state_d = SPMSP_IDLE;
            end else begin
               if (shft & (bits_q != 3'h0 | samp)) sh_d = {sh_q[6:0], 1'b0};
               if (samp) begin
                  bits_d = bits_q + 3'h1;
                  if (bits_q == `SPMSP_BIT_LAST) begin
                     xfer_end = 1'b1;
                     rx_push = 1'b1;
                     rx_d = 8'h00;
                     if (!tx_empty) begin
                        tx_pop = 1'b1;
                        sh_d = tx_rdata;
                     end else begin
                        state_d = SPMSP_SSKIP;
                     end
                  end
               end
            end
         end
         SPMSP_SSKIP: begin
            rx_d = 8'h00;
            if (!en | mst | s2_q.ss_n) state_d = SPMSP_IDLE;
         end
      endcase
   end

   // Flags, byte count and pin enables
   always_comb begin
      done_set = 1'b0;
      cnt_d = cnt_q;
      if (xfer_end) begin
         if (cnt_q == ext_q.cnt_sel) begin
            cnt_d = 2'h0;
            done_set = 1'b1;
         end else begin
            cnt_d = cnt_q + 2'h1;
         end
      end
      // A new event beats a clear in the same cycle
      done_d = done_set | (done_q & ~done_clr);
      write_collision_flag_d = write_collision_flag_set | (write_collision_flag_q & ~write_collision_flag_clr);
      irq_d = ctrl_q.irq_en & done_q;
      moe_d = en & mst;
      soe_d = (state_d == SPMSP_SXFER);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         mi1_q <= 1'b0;
         mi2_q <= 1'b0;
      end else begin
         s1_q <= '{sck: spi_sck_i, mosi: spi_mosi_i, ss_n: spi_ss_n_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
         mi1_q <= spi_miso_i;
         mi2_q <= mi1_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= spmsp_ctrl_t'(`SPMSP_CTRL_RST);
         ext_q <= spmsp_ext_t'(`SPMSP_EXT_RST);
         vpm_q <= `SPMSP_VPM_RST;
         pend_q <= 1'b0;
         rdy_q <= 1'b1;
         wr_q <= 1'b0;
         idx_q <= 16'h0000;
         rd_q <= 32'h0000_0000;
         done_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         irq_q <= 1'b0;
         cnt_q <= 2'h0;
         state_q <= SPMSP_IDLE;
         half_q <= 4'h0;
         bits_q <= 3'h0;
         sh_q <= 8'h00;
         rx_q <= 8'h00;
         sck_q <= 1'b0;
         moe_q <= 1'b0;
         soe_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         ext_q <= ext_d;
         vpm_q <= vpm_d;
         pend_q <= pend_d;
         rdy_q <= rdy_d;
         wr_q <= wr_d;
         idx_q <= idx_d;
         rd_q <= rd_d;
         done_q <= done_d;
         write_collision_flag_q <= write_collision_flag_d;
         irq_q <= irq_d;
         cnt_q <= cnt_d;
         state_q <= state_d;
         half_q <= half_d;
         bits_q <= bits_d;
         sh_q <= sh_d;
         rx_q <= rx_d;
         sck_q <= sck_d;
         moe_q <= moe_d;
         soe_q <= soe_d;
      end
   end

   assign hrdata = rd_q;
   assign hreadyout = rdy_q;
   // Only OKAY is ever answered
   assign hresp = 1'b0;
   assign xfer_irq = irq_q;
   assign spi_sck_o = sck_q;
   assign spi_sck_oe = moe_q;
   assign spi_mosi_o = sh_q[7];
   assign spi_mosi_oe = moe_q;
   assign spi_miso_o = sh_q[7];
   assign spi_miso_oe = soe_q;
endmodule : spmsp_port

// ### testbench/spmsp_port_asserts.sv
// Concurrent checks on the serial port bus and pin behaviour
module spmsp_port_asserts
   import spmsp_pkg::*;
(
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, low
   input wire logic hsel, // Slave select
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic hready, // Bus ready
   input wire logic hreadyout, // Slave ready
   input wire logic hresp, // Response
   input wire logic xfer_irq, // Completion interrupt
   input wire logic spi_sck_o, // Clock pin out
   input wire logic spi_sck_oe, // Clock pin drive
   input wire logic spi_mosi_oe, // Master-out drive
   input wire logic spi_miso_oe // Master-in drive
);
   timeunit 1ns;
   timeprecision 1ns;
   logic take;
   logic [2:0] wr_h_q;
   logic [2:0] wr_h_d;
   assign take = hsel && hready && htrans[1];
   // Writes of the last three cycles excuse idle level changes; only the older two excuse interrupt drops
   always_comb begin
      wr_h_d = {wr_h_q[1:0], take && hwrite};
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_h_q <= 3'h0;
      end else begin
         wr_h_q <= wr_h_d;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_take;
      hsel && hready && htrans[1];
   endsequence
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   a_bus_wait: assert property (s_take |=> s_wait)
      else $error("data phase is not one wait");
   a_wait_cause: assert property ($fell(hreadyout) |-> $past(take))
      else $error("wait without a taken transfer");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_sck_half: assert property (spi_sck_oe && $changed(spi_sck_o)
      |=> $stable(spi_sck_o) [*3])
      else $error("clock half period below four cycles");
   a_pins_pair: assert property (spi_mosi_oe == spi_sck_oe)
      else $error("data and clock drive differ");
   a_roles_apart: assert property (spi_miso_oe |-> !spi_sck_oe)
      else $error("master and slave drive together");
   a_irq_drop: assert property ($fell(xfer_irq) |-> |wr_h_q[2:1])
      else $error("interrupt fell without a write");
   a_sck_idle: assert property (!spi_sck_oe && $changed(spi_sck_o)
      |-> |wr_h_q)
      else $error("idle clock moved without a write");
endmodule : spmsp_port_asserts

bind spmsp_port spmsp_port_asserts u_chk (.hclk, .hresetn, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .hresp, .xfer_irq, .spi_sck_o, .spi_sck_oe,
   .spi_mosi_oe, .spi_miso_oe);

// ### testbench/spmsp_slave_model.sv
// Serial slave that answers the port while it is master
module spmsp_slave_model
   import spmsp_pkg::*;
(
   input wire logic sck, // Serial clock
   input wire logic sel, // Port drives the clock
   input wire logic mosi, // Data from port
   input wire logic [7:0] tx_i, // Byte to answer
   output logic miso, // Data to port
   output logic [7:0] rx_o // Last bits taken
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt_q = 3'h0;
   logic [7:0] rx_q = 8'h00;
   logic bit_w;
   assign bit_w = tx_i[3'h7 - cnt_q];
   // Released line shows the inverse so a stale bit cannot pass
   assign miso = sel ? bit_w : ~bit_w;
   assign rx_o = rx_q;
   always @(posedge sck) rx_q <= {rx_q[6:0], mosi};
   // Gated so the reset edge at time zero does not count
   always @(negedge sck) if (sel === 1'b1) cnt_q <= cnt_q + 3'h1;
endmodule : spmsp_slave_model

// ### testbench/test_spmsp_port.sv
// Register and serial traffic tests of the serial port
`define CHK(got, exp) begin \
   n_compared++; \
   if ((got) !== (exp)) begin \
      fails++; \
      $display("[ERR] %0t got %h exp %h", $time, got, exp); \
   end \
end
module test_spmsp_port import spmsp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, ss_n, t_sck, t_mosi;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, xfer_irq, s_miso;
   logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
   logic [7:0] s_tx, s_rx, b;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   int n;
   logic [31:0] ra[6] = '{32'h9500, 32'h9504, 32'h950C, 32'h9DFC,
      32'h9508, 32'h9600};
   logic [7:0] rv[6] = '{8'h10, 8'h05, 8'h02, 8'h00, 8'h00, 8'h00};

   always #5 hclk = ~hclk;

   spmsp_port uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .xfer_irq(xfer_irq),
      .spi_sck_i(sck_oe ? sck_o : t_sck), .spi_sck_o(sck_o),
      .spi_sck_oe(sck_oe), .spi_mosi_i(mosi_oe ? mosi_o : t_mosi),
      .spi_mosi_o(mosi_o), .spi_mosi_oe(mosi_oe),
      .spi_miso_i(miso_oe ? miso_o : s_miso), .spi_miso_o(miso_o),
      .spi_miso_oe(miso_oe), .spi_ss_n_i(ss_n));

   spmsp_slave_model slv (.sck(sck_o), .sel(sck_oe), .mosi(mosi_o),
      .tx_i(s_tx), .miso(s_miso), .rx_o(s_rx));

   task automatic xfer(input logic w, input logic [31:0] a,
      input logic [7:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : xfer

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [7:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 8'h00, r);
      `CHK(r, {24'h0, e})
   endtask : rd

   task automatic rst();
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask : rst

   // External master; its clock idles at lvl, first edge samples
   task automatic sframe(input logic lvl, input logic [7:0] m,
      output logic [7:0] s);
      t_sck <= lvl;
      ss_n <= 1'b0;
      repeat (8) @(posedge hclk);
      for (int i = 7; i >= 0; i--) begin
         t_mosi <= m[i];
         repeat (8) @(posedge hclk);
         s[i] = miso_oe ? miso_o : s_miso;
         t_sck <= ~lvl;
         repeat (8) @(posedge hclk);
         t_sck <= lvl;
      end
      repeat (8) @(posedge hclk);
      ss_n <= 1'b1;
      t_mosi <= ~m[0];
      repeat (8) @(posedge hclk);
   endtask : sframe

   task automatic fin(input string s);
      $display("test %s done", s);
   endtask : fin

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_of_test();
      end
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      ss_n = 1'b1;
      t_sck = 1'b1;
      t_mosi = 1'b0;
      s_tx = 8'h3C;
      rst();
      wr(32'h9600, 8'hFF);
      foreach (ra[i]) rd(ra[i], rv[i]);
      fin("reset");
      for (int i = 0; i < 2; i++) begin
         wr(32'h950C, i ? 8'h41 : 8'h00);
         wr(32'h9500, i ? 8'hD1 : 8'hD3);
         wr(32'h9508, 8'hA5);
         if (i) wr(32'h9508, 8'hA5);
         n = 0;
         while (xfer_irq !== 1'b1) begin
            @(posedge hclk);
            n++;
         end
         `CHK(n >= 250 && n < 300, 1'b1)
         `CHK(s_rx, 8'hA5)
         rd(32'h9508, 8'h3C);
         if (i) rd(32'h9508, 8'h3C);
         rd(32'h9504, 8'h85);
         wr(32'h9504, 8'h00);
         rd(32'h9504, 8'h05);
      end
      fin("master");
      wr(32'h9500, 8'h48);
      // Flag on every byte again, the master test left two
      wr(32'h950C, 8'h00);
      `CHK(sck_o, 1'b1)
      sframe(1'b1, 8'h5A, b);
      rd(32'h9504, 8'h05);
      wr(32'h9508, 8'h96);
      sframe(1'b1, 8'h5A, b);
      `CHK(b, 8'h96)
      rd(32'h9508, 8'h5A);
      rd(32'h9504, 8'h85);
      wr(32'h9500, 8'h40);
      wr(32'h9508, 8'hC3);
      `CHK(sck_o, 1'b0)
      sframe(1'b0, 8'h81, b);
      `CHK(b, 8'hC3)
      rd(32'h9508, 8'h81);
      fin("slave");
      rst();
      for (int i = 0; i < 16; i++) wr(32'h9508, 8'h11);
      rd(32'h9504, 8'h09);
      wr(32'h9508, 8'h22);
      rd(32'h9504, 8'h49);
      wr(32'h9504, 8'h00);
      rd(32'h9504, 8'h09);
      rst();
      wr(32'h9DFC, 8'h03);
      rd(32'h9DFC, 8'h03);
      for (int i = 0; i < 17; i++) wr(32'h9508, 8'h33);
      rd(32'h9504, 8'h01);
      fin("fifo");
      end_of_test();
   end
endmodule : test_spmsp_port
